// [rtl/apt_map.svh]
// Purpose: constants for the autonomous periodic timer
// Assumes: single clock mclk at 10 MHz
// Notes: no bus, so no offsets; widths, reset values and the mclk period only
`ifndef APT_MAP_SVH
`define APT_MAP_SVH

`define APT_PERIOD_W      16
`define APT_PERIOD_RST    16'h0000
`define APT_SRC_RST       1'b0
`define APT_CLK_PERIOD_NS 100

`endif

// [rtl/apt_pkg.sv]
// Purpose: types for the autonomous periodic timer
// Assumes: apt_map.svh holds the numbers
// Notes: state enum and config carrier
`include "apt_map.svh"
package apt_pkg;
	typedef enum logic [0:0] {
		APT_IDLE = 1'b0,
		APT_RUN  = 1'b1
	} apt_state_t;

	typedef struct packed {
		logic                       timerEnable;
		logic                       clockSourceSelect;
		logic                       interruptEnable;
		logic [`APT_PERIOD_W-1:0]   periodLengthValue;
	} apt_cfg_t;
endpackage

// [rtl/apt_tick_sel.sv]
// Purpose: selects the counting tick for the periodic timer
// Assumes: rcTick is a one-cycle pulse synchronous to mclk
// Notes: bus source counts every cycle the bus clock runs
`timescale 1ns/1ps
module apt_tick_sel (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic clkEn,
	input  wire logic sourceSel,
	input  wire logic rcTick,
	input  wire logic busClockOn,
	output logic      tick
);
	logic tick_reg;
	logic tick_next;

	always_comb begin
		tick_next = sourceSel ? rcTick : busClockOn;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tick_reg <= 1'b0;
		end else if (clkEn) begin
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule // apt_tick_sel

// [rtl/apt_timer.sv]
// Purpose: autonomous periodic interrupt timer
// Assumes: control bits are plain ports sampled on mclk
// Notes: select 1 picks the rc oscillator tick, 0 the bus clock
//
// Behaviour
// - timer stopped unless enable bit set
// - counts on rc oscillator or bus clock
// - source select writable only while disabled
// - bus source freezes while bus clock off
// - period length from 16-bit value
// - period value writable only while disabled
// - enable starts a full new period
// - elapsed flag set at period end
// - interrupt while flag and enable both one
// - timer restarts itself after each period
`timescale 1ns/1ps
`include "apt_map.svh"
module apt_timer (
	input  wire logic                       mclk,
	input  wire logic                       sys_rst,
	input  wire logic                       clkEn,
	input  wire logic                       enableWrite,
	input  wire logic                       enableData,
	input  wire logic                       sourceWrite,
	input  wire logic                       sourceData,
	input  wire logic                       periodWrite,
	input  wire logic [`APT_PERIOD_W-1:0]   periodData,
	input  wire logic                       intEnWrite,
	input  wire logic                       intEnData,
	input  wire logic                       flagClearOne,
	input  wire logic                       rcTick,
	input  wire logic                       busClockOn,
	output apt_pkg::apt_cfg_t               cfgOut,
	output logic                            periodElapsedFlag,
	output logic                            irqReq,
	output logic [`APT_PERIOD_W-1:0]        countOut
);
	import apt_pkg::*;

	////////////////////////////////////////////////////////////////////////
	apt_cfg_t                  cfg_reg;
	apt_cfg_t                  cfg_next;
	apt_state_t                state_reg;
	apt_state_t                state_next;
	logic [`APT_PERIOD_W-1:0]  cnt_reg;
	logic [`APT_PERIOD_W-1:0]  cnt_next;
	logic                      flag_reg;
	logic                      flag_next;
	logic                      irq_reg;
	logic                      irq_next;
	logic                      tick;
	logic                      done;

	apt_tick_sel u_tick (
		.mclk       (mclk),
		.sys_rst    (sys_rst),
		.clkEn      (clkEn),
		.sourceSel  (cfg_reg.clockSourceSelect),
		.rcTick     (rcTick),
		.busClockOn (busClockOn),
		.tick       (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// configuration bits
	always_comb begin
		cfg_next = cfg_reg;
		if (enableWrite) begin
			cfg_next.timerEnable = enableData;
		end
		if (sourceWrite && !cfg_reg.timerEnable) begin
			cfg_next.clockSourceSelect = sourceData;
		end
		if (periodWrite && !cfg_reg.timerEnable) begin
			cfg_next.periodLengthValue = periodData;
		end
		if (intEnWrite) begin
			cfg_next.interruptEnable = intEnData;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counter and state
	// count runs 0 .. period; period value 0 treated as one tick
	assign done = tick && (cnt_reg >= cfg_reg.periodLengthValue);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			APT_IDLE: begin
				cnt_next = '0;
				if (cfg_reg.timerEnable) begin
					state_next = APT_RUN;
				end
			end
			APT_RUN: begin
				if (!cfg_reg.timerEnable) begin
					state_next = APT_IDLE;
					cnt_next   = '0;
				end else if (done) begin
					cnt_next = '0;
				end else if (tick) begin
					cnt_next = cnt_reg + 16'h0001;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// flag and interrupt
	always_comb begin
		flag_next = flag_reg;
		if (flagClearOne) begin
			flag_next = 1'b0;
		end
		if (state_reg == APT_RUN && cfg_reg.timerEnable && done) begin
			flag_next = 1'b1;
		end
		irq_next = flag_next && cfg_next.interruptEnable;
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_reg   <= '{timerEnable: 1'b0, clockSourceSelect: `APT_SRC_RST,
				interruptEnable: 1'b0, periodLengthValue: `APT_PERIOD_RST};
			state_reg <= APT_IDLE;
			cnt_reg   <= '0;
			flag_reg  <= 1'b0;
			irq_reg   <= 1'b0;
		end else if (clkEn) begin
			cfg_reg   <= cfg_next;
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			flag_reg  <= flag_next;
			irq_reg   <= irq_next;
		end
	end

	assign cfgOut            = cfg_reg;
	assign periodElapsedFlag = flag_reg;
	assign irqReq            = irq_reg;
	assign countOut          = cnt_reg;
endmodule // apt_timer

// [sim/apt_timer_bench.sv]
// Purpose: directed bench for apt_timer
// Assumes: select 0 is bus clock
// Notes: period 4 gives five ticks
`timescale 1ns/1ps
module apt_timer_bench;
	import apt_pkg::*;
	logic        mclk = 1'h0, sys_rst = 1'h1, clkEn = 1'h1, rcTick = 1'h0, busClockOn = 1'h0;
	logic        enableWrite = 1'h0, enableData = 1'h0, sourceWrite = 1'h0, sourceData = 1'h0;
	logic        periodWrite = 1'h0, intEnWrite = 1'h0, intEnData = 1'h0, flagClearOne = 1'h0;
	logic [15:0] periodData = 16'h0000, countOut, a;
	logic        periodElapsedFlag, irqReq;
	apt_cfg_t    cfgOut;
	int          failures = 0, total_checks = 0, n;
	always #50 mclk = ~mclk;
	apt_timer dut (.*);
	task automatic wr(input int k, input logic [15:0] d);
		@(posedge mclk) #1;
		{enableWrite, sourceWrite, periodWrite, intEnWrite, flagClearOne} = 5'h10 >> k;
		{enableData, sourceData, intEnData, periodData} = {d[0], d[0], d[0], d};
		@(posedge mclk) #1;
		{enableWrite, sourceWrite, periodWrite, intEnWrite, flagClearOne} = 5'h00;
	endtask
	task automatic chk(input logic [31:0] v, e);
		total_checks++;
		if (v !== e) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, v, e);
		end
	endtask
	task automatic till(input logic [15:0] v);
		n = 0;
		do begin
			@(posedge mclk) #1;
			n++;
		end while (countOut !== v && n < 50);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge mclk) #1;
		sys_rst = 1'h0;
		chk(cfgOut, 0);
		wr(2, 16'h0004);
		wr(3, 16'h0001);
		wr(0, 16'h0001);
		busClockOn = 1'h1;
		wr(2, 16'h0009);
		chk(cfgOut.periodLengthValue, 4);
		wr(1, 16'h0001);
		chk(cfgOut.clockSourceSelect, 0);
		till(4);
		till(4);
		chk(n, 5);
		chk({periodElapsedFlag, irqReq}, 3);
		wr(4, 16'h0001);
		chk(periodElapsedFlag, 0);
		busClockOn = 1'h0;
		repeat (2) @(posedge mclk) #1;
		a = countOut;
		repeat (3) @(posedge mclk) #1;
		chk(countOut, a);
		busClockOn = 1'h1;
		wr(0, 16'h0000);
		repeat (3) @(posedge mclk) #1;
		chk(countOut, 0);
		busClockOn = 1'h0;
		wr(1, 16'h0001);
		chk(cfgOut.clockSourceSelect, 1);
		rcTick = 1'h1;
		wr(0, 16'h0001);
		till(4);
		till(4);
		chk(n, 5);
		wr(3, 16'h0000);
		chk({periodElapsedFlag, irqReq}, 2);
		clkEn = 1'h0;
		a = countOut;
		repeat (3) @(posedge mclk) #1;
		chk(countOut, a);
		clkEn = 1'h1;
		test_done;
	end
	initial begin
		#100000;
		failures++;
		test_done;
	end
endmodule // apt_timer_bench

// [sim/apt_timer_monitor.sv]
// Purpose: port checks for apt_timer
// Assumes: bound to every apt_timer
// Notes: none
`timescale 1ns/1ps
module apt_timer_monitor (
	input wire logic         mclk,
	input wire logic         sys_rst,
	input wire logic         clkEn,
	input wire logic         sourceWrite,
	input wire logic         periodWrite,
	input wire logic         flagClearOne,
	input wire logic         busClockOn,
	input apt_pkg::apt_cfg_t cfgOut,
	input wire logic         periodElapsedFlag,
	input wire logic         irqReq,
	input wire logic [15:0]  countOut
);
	import apt_pkg::*;
	wire        en  = cfgOut.timerEnable;
	wire [15:0] per = cfgOut.periodLengthValue;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	chk_src_locked: assert property (en && sourceWrite |=> $stable(cfgOut.clockSourceSelect))
		else $error("source changed while running");
	chk_per_locked: assert property (en && periodWrite |=> $stable(per))
		else $error("period changed while running");
	chk_stop_zero: assert property (!en ##1 !en |-> countOut == 16'h0000)
		else $error("count moved while stopped");
	chk_count_range: assert property (en |-> countOut <= per)
		else $error("count beyond period");
	chk_wrap_flag: assert property (en && $past(en) && $past(countOut) == per && per != 16'h0000 && countOut == 16'h0000 |-> periodElapsedFlag)
		else $error("wrap without flag");
	chk_flag_hold: assert property (periodElapsedFlag && !(flagClearOne && clkEn) |=> periodElapsedFlag)
		else $error("flag dropped without clear");
	chk_irq_match: assert property (irqReq == (periodElapsedFlag && cfgOut.interruptEnable))
		else $error("irq mismatch");
	chk_bus_freeze: assert property (en && clkEn && !cfgOut.clockSourceSelect && !busClockOn ##1 en ##1 en |-> $stable(countOut))
		else $error("count moved without bus clock");
endmodule // apt_timer_monitor
bind apt_timer apt_timer_monitor mon (.*);
